// File: pwm_b_enable_ctrl.sv
// Purpose: generator b enable control with apb registers
// Assumes: pclk 20 MHz, pins synchronised by two flip-flops
// Notes: edge-aligned compare output per channel
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module pwm_b_enable_ctrl
  import pwm_b_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        global_load_okay,
  input  wire logic        commutation_event,
  output logic             pwm_out_ch2,
  output logic             pwm_out_ch3,
  output logic             reload_irq_b,
  output logic             irq
);
  // register state
  logic                  gen_b_enable_q;
  logic                  global_load_select_b_q;
  logic                  restart_on_commutation_b_q;
  logic                  load_okay_b_q;
  logic                  reload_irq_enable_b_q;
  logic                  reload_flag_b_q;
  logic [ldfq_width-1:0] reload_frequency_b_q;
  logic [prsc_width-1:0] prescaler_select_b_q;
  logic [cnt_width-1:0]  period_modulus_b_q;
  logic [pw_width-1:0]   pw2_q;
  logic [pw_width-1:0]   pw3_q;
  logic                  independent_timebase_select_q;
  logic                  write_protect_q;
  logic [1:0]            software_output_control_q;
  logic [1:0]            software_output_value_q;
  logic [ev_width-1:0]   irq_sts_q;
  logic [ev_width-1:0]   irq_en_q;
  // active copies
  logic [ldfq_width-1:0] act_ldfq_q;
  logic [prsc_width-1:0] act_prsc_q;
  logic [cnt_width-1:0]  act_mod_q;
  logic [pw_width-1:0]   act_pw2_q;
  logic [pw_width-1:0]   act_pw3_q;
  logic [ldfq_width-1:0] opp_cnt_q;
  logic                  first_q;
  logic                  ldok_armed_q;
  logic                  rf_armed_q;
  logic [31:0]           prdata_q;
  logic                  pwm_out_ch2_q;
  logic                  pwm_out_ch3_q;
  // pin synchronisers
  logic                  glo_s1_q;
  logic                  glo_s2_q;
  logic                  com_s1_q;
  logic                  com_s2_q;
  logic                  com_s3_q;

  logic                  cycle_start;
  logic [cnt_width-1:0]  count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glo_s1_q <= 1'b0;
      glo_s2_q <= 1'b0;
      com_s1_q <= 1'b0;
      com_s2_q <= 1'b0;
      com_s3_q <= 1'b0;
    end else begin
      glo_s1_q <= global_load_okay;
      glo_s2_q <= glo_s1_q;
      com_s1_q <= commutation_event;
      com_s2_q <= com_s1_q;
      com_s3_q <= com_s2_q;
    end
  end

  // apb decode
  wire setup    = psel && !penable;
  wire access   = psel && penable;
  wire wr       = access && pwrite;
  wire rd       = access && !pwrite;
  wire independent_timebase_select      = independent_timebase_select_q;
  wire hit_enc  = (paddr == enc_off);
  wire hit_fqc  = (paddr == fqc_off);
  wire hit_mod  = (paddr == mod_off);
  wire hit_pw2  = (paddr == pw2_off);
  wire hit_pw3  = (paddr == pw3_off);
  wire hit_cfg  = (paddr == cfg_off);
  wire hit_sts  = (paddr == irq_sts_off);
  wire hit_clr  = (paddr == irq_clr_off);
  wire hit_ien  = (paddr == irq_en_off);
  wire hit_cnt  = (paddr == cnt_off);
  wire mapped   = hit_enc | hit_fqc | hit_mod | hit_pw2 | hit_pw3 | hit_cfg
                | hit_sts | hit_clr | hit_ien | hit_cnt;
  // generator b registers take writes only with the timebase select set
  wire b_wr     = wr && independent_timebase_select;
  wire wr_enc   = b_wr && hit_enc;
  wire wr_fqc   = b_wr && hit_fqc;
  wire rd_enc   = rd && hit_enc;
  wire rd_fqc   = rd && hit_fqc;
  wire wr_cfg   = wr && hit_cfg;
  wire wr_clr   = wr && hit_clr;
  wire wr_ien   = wr && hit_ien;

  // generator and reload timing
  wire run        = gen_b_enable_q && independent_timebase_select;
  wire com_edge   = com_s2_q && !com_s3_q;
  wire restart    = run && restart_on_commutation_b_q && com_edge;
  wire opp_match  = (opp_cnt_q == act_ldfq_q);
  wire reload     = cycle_start && (first_q || opp_match);
  wire load_ok    = global_load_select_b_q ? glo_s2_q : load_okay_b_q;
  wire do_load    = reload && load_ok;

  // register reads
  wire [7:0] enc_view = {gen_b_enable_q, global_load_select_b_q, 3'h0,
                         restart_on_commutation_b_q, load_okay_b_q, reload_irq_enable_b_q};
  wire [7:0] fqc_view = {reload_frequency_b_q, 1'b0, prescaler_select_b_q, reload_flag_b_q};
  wire [5:0] cfg_view = {software_output_value_q, software_output_control_q,
                         write_protect_q, independent_timebase_select_q};
  wire [31:0] rd_mux  =
      hit_enc ? {24'h0, independent_timebase_select ? enc_view : 8'h00} :
      hit_fqc ? {24'h0, independent_timebase_select ? fqc_view : 8'h00} :
      hit_mod ? {17'h0, independent_timebase_select ? period_modulus_b_q : 15'h0} :
      hit_pw2 ? {16'h0, independent_timebase_select ? pw2_q : 16'h0} :
      hit_pw3 ? {16'h0, independent_timebase_select ? pw3_q : 16'h0} :
      hit_cfg ? {26'h0, cfg_view} :
      hit_sts ? {30'h0, irq_sts_q} :
      hit_ien ? {30'h0, irq_en_q} :
      hit_cnt ? {17'h0, independent_timebase_select ? count : 15'h0} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = access && !mapped;

  // enable control register
  wire wen  = pwdata[enc_en_bit];
  wire wldk = pwdata[enc_ldok_bit];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_b_enable_q             <= 1'b0;
      global_load_select_b_q     <= 1'b0;
      restart_on_commutation_b_q <= 1'b0;
      reload_irq_enable_b_q      <= 1'b0;
    end else if (wr_enc) begin
      gen_b_enable_q        <= wen;
      reload_irq_enable_b_q <= pwdata[enc_rie_bit];
      if (!write_protect_q) begin
        global_load_select_b_q     <= pwdata[enc_glds_bit];
        restart_on_commutation_b_q <= pwdata[enc_rst_bit];
      end
    end
  end

  // load okay: set after read-as-zero, cleared by write of zero or after a load without global select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_okay_b_q <= 1'b0;
      ldok_armed_q  <= 1'b0;
    end else begin
      if (rd_enc && independent_timebase_select) begin
        ldok_armed_q <= !load_okay_b_q;
      end else if (wr_enc) begin
        ldok_armed_q <= 1'b0;
      end
      if (wr_enc && wldk && ldok_armed_q) begin
        load_okay_b_q <= 1'b1;
      end else if (wr_enc && !wldk) begin
        load_okay_b_q <= 1'b0;
      end else if (do_load && !global_load_select_b_q) begin
        load_okay_b_q <= 1'b0;
      end
    end
  end

  // buffered frequency, prescaler, modulus and pulse widths
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_frequency_b_q <= ldfq_rst;
      prescaler_select_b_q <= prsc_rst;
      period_modulus_b_q   <= mod_rst;
      pw2_q                <= pw_rst;
      pw3_q                <= pw_rst;
    end else begin
      if (wr_fqc) begin
        reload_frequency_b_q <= pwdata[fqc_ldfq_lsb +: ldfq_width];
        prescaler_select_b_q <= pwdata[fqc_prsc_lsb +: prsc_width];
      end
      if (b_wr && hit_mod) begin
        period_modulus_b_q <= pwdata[cnt_width-1:0];
      end
      if (b_wr && hit_pw2) begin
        pw2_q <= pwdata[pw_width-1:0];
      end
      if (b_wr && hit_pw3) begin
        pw3_q <= pwdata[pw_width-1:0];
      end
    end
  end

  // reload flag: a reload between read and write-one defeats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_flag_b_q <= 1'b0;
      rf_armed_q      <= 1'b0;
    end else begin
      if (reload) begin
        rf_armed_q <= 1'b0;
      end else if (rd_fqc && independent_timebase_select) begin
        rf_armed_q <= reload_flag_b_q;
      end else if (wr_fqc) begin
        rf_armed_q <= 1'b0;
      end
      if (reload) begin
        reload_flag_b_q <= 1'b1;
      end else if (wr_fqc && pwdata[fqc_rf_bit] && rf_armed_q) begin
        reload_flag_b_q <= 1'b0;
      end
    end
  end

  // active values only change at a reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ldfq_q <= ldfq_rst;
      act_prsc_q <= prsc_rst;
      act_mod_q  <= mod_rst;
      act_pw2_q  <= pw_rst;
      act_pw3_q  <= pw_rst;
      opp_cnt_q  <= '0;
      first_q    <= 1'b0;
    end else begin
      if (!run) begin
        first_q   <= 1'b1;
        opp_cnt_q <= '0;
      end else if (cycle_start) begin
        first_q   <= 1'b0;
        opp_cnt_q <= reload ? '0 : opp_cnt_q + 1'b1;
      end
      if (reload) begin
        act_ldfq_q <= reload_frequency_b_q;
      end
      if (do_load) begin
        act_prsc_q <= prescaler_select_b_q;
        act_mod_q  <= period_modulus_b_q;
        act_pw2_q  <= pw2_q;
        act_pw3_q  <= pw3_q;
      end
    end
  end

  // configuration: write lock is set-only until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      independent_timebase_select_q <= 1'b0;
      write_protect_q               <= 1'b0;
      software_output_control_q     <= 2'h0;
      software_output_value_q       <= 2'h0;
    end else if (wr_cfg) begin
      independent_timebase_select_q <= pwdata[cfg_mtg_bit];
      write_protect_q               <= write_protect_q | pwdata[cfg_wp_bit];
      software_output_control_q     <= {pwdata[cfg_oc3_bit], pwdata[cfg_oc2_bit]};
      software_output_value_q       <= {pwdata[cfg_ov3_bit], pwdata[cfg_ov2_bit]};
    end
  end

  // event status: set wins over a clear in the same cycle
  wire [ev_width-1:0] ev_set = {restart, reload};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q <= '0;
      irq_en_q  <= '0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~(wr_clr ? pwdata[ev_width-1:0] : '0)) | ev_set;
      if (wr_ien) begin
        irq_en_q <= pwdata[ev_width-1:0];
      end
    end
  end

  pwm_b_timebase #(
    .width(cnt_width)
  ) u_timebase (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (run),
    .restart    (restart),
    .prsc       (act_prsc_q),
    .modulus    (act_mod_q),
    .cycle_start(cycle_start),
    .count      (count)
  );

  // outputs: software level when selected, else compare while running or inactive low
  wire cmp2 = run && ({1'b0, count} < act_pw2_q);
  wire cmp3 = run && ({1'b0, count} < act_pw3_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out_ch2_q <= 1'b0;
      pwm_out_ch3_q <= 1'b0;
    end else begin
      pwm_out_ch2_q <= software_output_control_q[0] ? software_output_value_q[0] : cmp2;
      pwm_out_ch3_q <= software_output_control_q[1] ? software_output_value_q[1] : cmp3;
    end
  end

  assign pwm_out_ch2  = pwm_out_ch2_q;
  assign pwm_out_ch3  = pwm_out_ch3_q;
  assign reload_irq_b = reload_flag_b_q && reload_irq_enable_b_q;
  assign irq          = |(irq_sts_q & irq_en_q);
endmodule : pwm_b_enable_ctrl

// File: pwm_b_pkg.sv
// Purpose: constants for the generator b enable control block
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package pwm_b_pkg;
  localparam logic [7:0] enc_off     = 8'h00;
  localparam logic [7:0] fqc_off     = 8'h04;
  localparam logic [7:0] mod_off     = 8'h08;
  localparam logic [7:0] pw2_off     = 8'h0c;
  localparam logic [7:0] pw3_off     = 8'h10;
  localparam logic [7:0] cfg_off     = 8'h14;
  localparam logic [7:0] irq_sts_off = 8'h18;
  localparam logic [7:0] irq_clr_off = 8'h1c;
  localparam logic [7:0] irq_en_off  = 8'h20;
  localparam logic [7:0] cnt_off     = 8'h24;

  // enable control bit positions
  localparam int enc_en_bit   = 7;
  localparam int enc_glds_bit = 6;
  localparam int enc_rst_bit  = 2;
  localparam int enc_ldok_bit = 1;
  localparam int enc_rie_bit  = 0;
  // frequency control fields
  localparam int fqc_ldfq_lsb = 4;
  localparam int fqc_prsc_lsb = 1;
  localparam int fqc_rf_bit   = 0;
  // configuration bits
  localparam int cfg_mtg_bit  = 0;
  localparam int cfg_wp_bit   = 1;
  localparam int cfg_oc2_bit  = 2;
  localparam int cfg_oc3_bit  = 3;
  localparam int cfg_ov2_bit  = 4;
  localparam int cfg_ov3_bit  = 5;
  // event bits
  localparam int ev_reload_bit  = 0;
  localparam int ev_restart_bit = 1;
  localparam int ev_width       = 2;

  localparam int cnt_width  = 15;
  localparam int pw_width   = 16;
  localparam int ldfq_width = 4;
  localparam int prsc_width = 2;
  localparam int div_width  = 3;

  localparam logic [cnt_width-1:0]  mod_rst  = 15'h7fff;
  localparam logic [pw_width-1:0]   pw_rst   = 16'h0000;
  localparam logic [ldfq_width-1:0] ldfq_rst = 4'h0;
  localparam logic [prsc_width-1:0] prsc_rst = 2'h0;

  // terminal count of the prescaler divider: divide by 1, 2, 4, 8
  function automatic logic [div_width-1:0] div_last(input logic [prsc_width-1:0] sel);
    div_last = div_width'((4'h1 << sel) - 4'h1);
  endfunction : div_last
endpackage : pwm_b_pkg

// File: pwm_b_timebase.sv
// Purpose: prescaled period counter for generator b
// Assumes: single clock, enable-pulse prescaler
// Notes: cycle_start pulses for one cycle at each wrap to zero and at each start or restart
`timescale 1ns/1ps
module pwm_b_timebase
  import pwm_b_pkg::*;
#(
  parameter int width = cnt_width
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  run,
  input  wire logic                  restart,
  input  wire logic [prsc_width-1:0] prsc,
  input  wire logic [width-1:0]      modulus,
  output logic                       cycle_start,
  output logic [width-1:0]           count
);
  logic [div_width-1:0] div_q;
  logic [width-1:0]     cnt_q;
  logic                 started_q;
  logic                 start_q;
  wire                  tick    = (div_q == div_last(prsc));
  wire                  wrap    = tick && (cnt_q >= modulus);
  wire                  kick    = run && (!started_q || restart);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q     <= '0;
      cnt_q     <= '0;
      started_q <= 1'b0;
      start_q   <= 1'b0;
    end else if (!run) begin
      div_q     <= '0;
      cnt_q     <= '0;
      started_q <= 1'b0;
      start_q   <= 1'b0;
    end else begin
      started_q <= 1'b1;
      start_q   <= kick || wrap;
      if (kick) begin
        div_q <= '0;
        cnt_q <= '0;
      end else begin
        div_q <= tick ? '0 : div_q + 1'b1;
        if (tick) begin
          cnt_q <= wrap ? '0 : cnt_q + 1'b1;
        end
      end
    end
  end

  assign cycle_start = start_q;
  assign count       = cnt_q;
endmodule : pwm_b_timebase

// File: pwm_b_enable_ctrl_sva.sv
// Purpose: port-level checks for the generator b enable control
// Assumes: apb writes land at the access edge; one clock domain
// Notes: shadows hold only software-written bits, never hardware-owned ones
`timescale 1ns/1ps
module pwm_b_enable_ctrl_sva
  import pwm_b_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        global_load_okay,
  input wire logic        commutation_event,
  input wire logic        pwm_out_ch2,
  input wire logic        pwm_out_ch3,
  input wire logic        reload_irq_b,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic en_q, rie_q, glds_q, rst_q, mtg_q, wp_q, oc2_q, oc3_q, ov2_q;
  wire  wr_acc = psel && penable && pwrite;
  wire  rd_acc = psel && penable && !pwrite;
  wire  wr_enc = wr_acc && paddr == enc_off && mtg_q;
  wire  wr_cfg = wr_acc && paddr == cfg_off;
  wire  gated  = paddr inside {enc_off, fqc_off, mod_off, pw2_off, pw3_off, cnt_off};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {en_q, rie_q, glds_q, rst_q, mtg_q, wp_q, oc2_q, oc3_q, ov2_q} <= '0;
    end else begin
      if (wr_enc) begin
        {en_q, rie_q} <= {pwdata[enc_en_bit], pwdata[enc_rie_bit]};
      end
      if (wr_enc && !wp_q) begin
        {glds_q, rst_q} <= {pwdata[enc_glds_bit], pwdata[enc_rst_bit]};
      end
      if (wr_cfg) begin
        {mtg_q, oc2_q, oc3_q, ov2_q} <= {pwdata[cfg_mtg_bit], pwdata[cfg_oc2_bit],
                                         pwdata[cfg_oc3_bit], pwdata[cfg_ov2_bit]};
        wp_q <= wp_q | pwdata[cfg_wp_bit];
      end
    end
  end
  // three cycles of margin cover the registered output stage
  sequence s_rd_enc; rd_acc && paddr == enc_off && mtg_q; endsequence
  sequence s_off2; (!en_q && !oc2_q)[*3]; endsequence
  sequence s_off3; (!en_q && !oc3_q)[*3]; endsequence
  sequence s_sw2; (!en_q && oc2_q && ov2_q)[*3]; endsequence
  property p_rd_zero; rd_acc && !mtg_q && gated |-> prdata == 32'h0; endproperty
  property p_rd_lock;
    s_rd_enc |-> prdata[enc_glds_bit] == glds_q && prdata[enc_rst_bit] == rst_q;
  endproperty
  property p_rd_en;
    s_rd_enc |-> prdata[enc_en_bit] == en_q && prdata[enc_rie_bit] == rie_q;
  endproperty
  property p_off_ch2; s_off2 |-> !pwm_out_ch2; endproperty
  property p_off_ch3; s_off3 |-> !pwm_out_ch3; endproperty
  property p_sw_ch2; s_sw2 |-> pwm_out_ch2; endproperty
  property p_irq_mask; !rie_q |-> !reload_irq_b; endproperty
  property p_irq_hold; reload_irq_b && !wr_acc |=> reload_irq_b; endproperty
  property p_first_reload; $rose(en_q) && rie_q |-> ##[1:8] reload_irq_b; endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("gated register read not zero");
  a_rd_lock: assert property (p_rd_lock)
    else $error("locked bits changed");
  a_rd_en: assert property (p_rd_en)
    else $error("enable bits read wrong");
  a_off_ch2: assert property (p_off_ch2)
    else $error("ch2 active while stopped");
  a_off_ch3: assert property (p_off_ch3)
    else $error("ch3 active while stopped");
  a_sw_ch2: assert property (p_sw_ch2)
    else $error("ch2 ignores software drive");
  a_irq_mask: assert property (p_irq_mask)
    else $error("reload request while masked");
  a_irq_hold: assert property (p_irq_hold)
    else $error("reload request dropped without a write");
  a_first_reload: assert property (p_first_reload)
    else $error("no reload after enable");
endmodule : pwm_b_enable_ctrl_sva

bind pwm_b_enable_ctrl pwm_b_enable_ctrl_sva i_sva (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .global_load_okay,
  .commutation_event, .pwm_out_ch2, .pwm_out_ch3, .reload_irq_b, .irq);

// File: pwm_b_power_stage.sv
// Purpose: power stage stand-in on the channel 2 and 3 outputs
// Assumes: outputs active high, sampled on pclk
// Notes: commutation pulse lasts four cycles so a two-stage sync cannot miss it
`timescale 1ns/1ps
module pwm_b_power_stage (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   pwm_out_ch2,
  input  wire logic   pwm_out_ch3,
  input  wire logic   fire,
  input  wire logic   meas,
  output logic        commutation_event,
  output logic [15:0] hi2,
  output logic [15:0] hi3
);
  logic [3:0] comm_q;
  assign commutation_event = |comm_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {comm_q, hi2, hi3} <= '0;
    end else begin
      comm_q <= {comm_q[2:0], fire};
      hi2    <= hi2 + 16'(meas & pwm_out_ch2);
      hi3    <= hi3 + 16'(meas & pwm_out_ch3);
    end
  end
endmodule : pwm_b_power_stage

// File: pwm_generator_b_enable_control_tb_top.sv
// Purpose: self-checking bench for the generator b enable control
// Assumes: pready answers in the access cycle; counter period is modulus+1
// Notes: reads are checked by a monitor against a queue of expectations
`timescale 1ns/1ps
module pwm_generator_b_enable_control_tb_top;
  import pwm_b_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, glo = 1'b0, fire = 1'b0, meas = 1'b0;
  logic        glo_hold = 1'b0, glo_lvl = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, ch2, ch3, rirq, irq, comm;
  logic [31:0] prdata;
  logic [15:0] hi2, hi3, pw;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0]  adr_q[$];
  int          n_errors = 0, compares = 0, cyc = 0, t0 = 0, t1 = 0;
  int          seed = 32'h683f;
  always #25 pclk = ~pclk;
  pwm_b_enable_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .global_load_okay(glo), .commutation_event(comm),
    .pwm_out_ch2(ch2), .pwm_out_ch3(ch3), .reload_irq_b(rirq), .irq);
  pwm_b_power_stage i_stage (.pclk, .presetn, .pwm_out_ch2(ch2), .pwm_out_ch3(ch3),
    .fire, .meas, .commutation_event(comm), .hi2, .hi3);
  task automatic stop_test;
    $display("counts: compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m = '1);
    exp_q.push_back(e);
    msk_q.push_back(m);
    adr_q.push_back(a);
    apb(1'b0, a, 32'(unsigned'($random(seed))));
  endtask : rd
  task automatic wait_rirq;
    do @(posedge pclk); while (rirq !== 1'b1);
  endtask : wait_rirq
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) chk("read_queue", 33'h1, 33'h0);
      else chk($sformatf("read_%h", adr_q.pop_front()), exp_q.pop_front(),
               {pslverr, prdata & msk_q.pop_front()});
    end
  end
  // a stuck handshake must end the run, not hang it
  always @(posedge pclk) begin
    // random pin level until a test needs it steady
    glo <= glo_hold ? glo_lvl : 1'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      $display("[ERR] cycle_limit exp %0d got %0d", 20000, cyc);
      stop_test();
    end
  end
  initial begin : main
    int f;
    int k;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wr(enc_off, 32'h87);
    rd(enc_off, 33'h0);
    rd(mod_off, 33'h0);
    rd(cnt_off, 33'h0);
    rd(8'h30, 33'h1_0000_0000);
    $display("test gated_access done");
    wr(cfg_off, 32'h01);
    rd(mod_off, 33'(mod_rst));
    wr(enc_off, 32'h04);
    wr(cfg_off, 32'h03);
    wr(enc_off, 32'h40);
    rd(enc_off, 33'h04);
    wr(enc_off, 32'h06);
    rd(enc_off, 33'h06);
    wr(enc_off, 32'h04);
    rd(enc_off, 33'h04);
    for (k = 0; k < 2; k++) begin
      wr(cfg_off, 32'h03 | (32'h04 << k) | (32'h10 << k));
      repeat (4) @(posedge pclk);
      chk("pwm_out_ch2", 33'(k == 0), 33'(ch2));
      chk("pwm_out_ch3", 33'(k == 1), 33'(ch3));
    end
    wr(cfg_off, 32'h03);
    $display("test lock_and_software_drive done");
    pw = 16'(1 + ($random(seed) & 7));
    wr(mod_off, 32'h9);
    wr(pw2_off, 32'(pw));
    wr(pw3_off, 32'h0);
    rd(enc_off, 33'h04);
    wr(enc_off, 32'h07);
    wr(enc_off, 32'h87);
    wait_rirq();
    rd(enc_off, 33'h85);
    rd(fqc_off, 33'h01);
    meas <= 1'b1;
    repeat (100) @(posedge pclk);
    meas <= 1'b0;
    @(posedge pclk);
    chk("ch2_high_cycles", 33'(pw) * 33'd10, 33'(hi2));
    chk("ch3_high_cycles", 33'h0, 33'(hi3));
    $display("test enable_and_load done");
    for (f = 0; f < 16; f++) begin
      wr(fqc_off, 32'(f) << 4);
      for (k = 0; k < 3; k++) begin
        wait_rirq();
        t1 = cyc - t0;
        t0 = cyc;
        rd(fqc_off, 33'(f << 4 | 1));
        wr(fqc_off, 32'(f << 4 | 1));
      end
      chk("reload_spacing", 33'((f + 1) * 10), 33'(t1));
    end
    $display("test reload_frequency done");
    wr(fqc_off, 32'h0);
    wait_rirq();
    rd(fqc_off, 33'h01);
    // one full period passes so a reload lands between read and write
    repeat (10) @(posedge pclk);
    wr(fqc_off, 32'h01);
    @(posedge pclk);
    chk("reload_irq_b", 33'h1, 33'(rirq));
    wr(enc_off, 32'h84);
    @(posedge pclk);
    chk("reload_irq_b", 33'h0, 33'(rirq));
    wr(enc_off, 32'h85);
    @(posedge pclk);
    chk("reload_irq_b", 33'h1, 33'(rirq));
    wr(irq_en_off, 32'h2);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    do @(posedge pclk); while (irq !== 1'b1);
    rd(irq_sts_off, 33'h2, 32'h2);
    wr(enc_off, 32'h04);
    repeat (4) @(posedge pclk);
    chk("pwm_out_ch2", 33'h0, 33'(ch2));
    wr(irq_en_off, 32'h3);
    wr(irq_clr_off, 32'h3);
    @(posedge pclk);
    chk("irq", 33'h0, 33'(irq));
    rd(irq_sts_off, 33'h0);
    $display("test restart_and_irq done");
    rd(enc_off, 33'h04);
    wr(enc_off, 32'h06);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wr(cfg_off, 32'h01);
    rd(enc_off, 33'h0);
    $display("test mid_reset done");
    // global select: only the synchronised pin decides the load, not load okay
    glo_hold <= 1'b1;
    wr(mod_off, 32'h9);
    wr(pw2_off, 32'(pw));
    wr(enc_off, 32'h40);
    rd(enc_off, 33'h40);
    wr(enc_off, 32'h42);
    for (k = 0; k < 2; k++) begin
      glo_lvl <= 1'(k);
      repeat (4) @(posedge pclk);
      wr(enc_off, 32'hc2);
      // first period after enable runs one cycle long, so let it pass
      repeat (20) @(posedge pclk);
      meas <= 1'b1;
      repeat (100) @(posedge pclk);
      meas <= 1'b0;
      wr(enc_off, 32'h42);
      chk("ch2_high_cycles", 33'(pw) * 33'(k * 10), 33'(hi2));
    end
    $display("test global_load done");
    stop_test();
  end
endmodule : pwm_generator_b_enable_control_tb_top
